// [src/irq_vector_and_lowpower_ctrl.sv]
// The register addresses and register access over Avalon-MM were decided locally.
module irq_vector_and_lowpower_ctrl (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 ce,
  input  wire logic [7:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic [31:0]               readdata,
  output logic                      waitrequest,
  input  wire logic                 instrDone,
  input  wire logic                 retiReq,
  input  wire logic [15:0]          nextPc,
  input  wire logic [15:0]          memRdata,
  input  wire logic [13:0]          irqEvt,
  input  wire logic [2:0]           nmiEvt,
  input  wire logic [2:0]           rstEvt,
  output irq_lp_pkg::mem_req_t      memReq,
  output logic [15:0]               pcOut,
  output logic                      pcLoad,
  output logic [15:0]               vecAddr,
  output irq_lp_pkg::clk_en_t       clkEn
);

  irq_lp_pkg::seq_state_t state_r;
  logic [2:0]             cnt_r;
  logic [15:0]            sr_r;
  logic [15:0]            srNxt;
  logic [15:0]            sp_r;
  logic [13:0]            pend_r;
  logic [13:0]            irqEn_r;
  logic [2:0]             nmiFlag_r;
  logic [2:0]             nmiEn_r;
  logic [2:0]             rstFlag_r;
  logic                   dcoSrc_r;
  logic [15:0]            vecTab [16];
  logic [3:0]             accIdx_r;
  logic [15:0]            reqVec;
  logic                   reqValid;
  logic [3:0]             selIdx;
  logic                   retTake;
  logic                   accTake;
  logic                   anyRst;
  logic                   busWr;
  logic                   waitreq_r;
  logic [31:0]            rdMux;
  logic [15:0]            wrMask;
  logic                   byteOnly;
  logic                   sfrAddr;
  logic                   sfrWr;
  irq_lp_pkg::mem_req_t   memReq_r;
  irq_lp_pkg::clk_en_t    clkEn_r;
  logic [15:0]            pc_r;
  logic                   pcLoad_r;
  logic [15:0]            vecAddr_r;

  function automatic irq_lp_pkg::clk_en_t lpDecode(input logic [15:0] sr, input logic dcoSrc);
    irq_lp_pkg::clk_en_t c;
    logic                h;
    logic                xo;
    logic                s0;
    logic                s1;
    h         = sr[irq_lp_pkg::SR_HALT];
    xo        = sr[irq_lp_pkg::SR_XOSC];
    s0        = sr[irq_lp_pkg::SR_LOOP_CTRL_STOP];
    s1        = sr[irq_lp_pkg::SR_DC_GEN_STOP];
    c.coreRun = !h;
    c.mainClk = !h;
    c.subClk  = !h || (!s1 && !xo);
    c.auxClk  = !h || !xo;
    c.xtal    = !h || !xo;
    c.digital_osc     = !h || !(s0 || s1 || xo);
    // a dco still feeding a clock keeps its dc generator alive
    c.dcGen   = !h || (!xo && !(s0 && s1) && !(s0 && !s1 && !dcoSrc));
    return c;
  endfunction : lpDecode

  assign anyRst   = |rstEvt;
  assign reqVec   = {1'b0, |(nmiFlag_r & nmiEn_r),
                     pend_r & irqEn_r & {14{sr_r[irq_lp_pkg::SR_GIE]}}};
  assign retTake  = state_r == irq_lp_pkg::ST_IDLE && retiReq && !anyRst;
  // a halted core never completes an instruction, so halt stands in for it
  assign accTake  = state_r == irq_lp_pkg::ST_IDLE && !retiReq && !anyRst && reqValid &&
                    (instrDone || sr_r[irq_lp_pkg::SR_HALT]);

  irq_prio_enc u_prio (
    .req   (reqVec),
    .valid (reqValid),
    .idx   (selIdx)
  );

  // bus slave: one wait cycle, then the access completes
  assign busWr    = ce && write && !waitreq_r;
  assign wrMask   = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign byteOnly = byteenable == 4'h1 || byteenable == 4'h2;
  assign sfrAddr  = address >= irq_lp_pkg::OFS_IRQ_EN && address <= irq_lp_pkg::OFS_RST_FLG;
  assign sfrWr    = busWr && sfrAddr && byteOnly;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      waitreq_r <= 1'b1;
    end else if (ce) begin
      waitreq_r <= !((read || write) && waitreq_r);
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    if (address[7:6] == irq_lp_pkg::VEC_PAGE) begin
      rdMux[15:0] = vecTab[address[5:2]];
    end else begin
      case (address)
        irq_lp_pkg::OFS_STATUS:   rdMux[15:0] = sr_r;
        irq_lp_pkg::OFS_SP:       rdMux[15:0] = sp_r;
        irq_lp_pkg::OFS_PC:       rdMux[15:0] = pc_r;
        irq_lp_pkg::OFS_IRQ_EN:   rdMux[13:0] = irqEn_r;
        irq_lp_pkg::OFS_IRQ_PEND: rdMux[13:0] = pend_r;
        irq_lp_pkg::OFS_NMI:      rdMux[10:0] = {nmiEn_r, 5'h00, nmiFlag_r};
        irq_lp_pkg::OFS_RST_FLG:  rdMux[2:0]  = rstFlag_r;
        irq_lp_pkg::OFS_CLK_CFG:  rdMux[0]    = dcoSrc_r;
        default:                  rdMux       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && waitreq_r) begin
      readdata <= rdMux;
    end
  end

  // vector words are memory, not reset: they survive every restart
  always_ff @(posedge clk_sys) begin
    if (ce && busWr && address[7:6] == irq_lp_pkg::VEC_PAGE) begin
      vecTab[address[5:2]] <= (vecTab[address[5:2]] & ~wrMask) | (writedata[15:0] & wrMask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irqEn_r  <= 14'h0000;
      dcoSrc_r <= 1'b0;
      nmiEn_r  <= 3'h0;
    end else if (ce) begin
      if (sfrWr && address == irq_lp_pkg::OFS_IRQ_EN) begin
        irqEn_r <= (irqEn_r & ~wrMask[13:0]) | (writedata[13:0] & wrMask[13:0]);
      end
      if (busWr && address == irq_lp_pkg::OFS_CLK_CFG && byteenable[0]) begin
        dcoSrc_r <= writedata[0];
      end
      if (accTake && selIdx == irq_lp_pkg::SLOT_NMI) begin
        nmiEn_r <= 3'h0;
      end else if (sfrWr && address == irq_lp_pkg::OFS_NMI && byteenable[1]) begin
        nmiEn_r <= writedata[10:8];
      end
    end
  end

  // flags: a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend_r    <= 14'h0000;
      nmiFlag_r <= 3'h0;
    end else if (ce) begin
      pend_r    <= (pend_r & ~((sfrWr && address == irq_lp_pkg::OFS_IRQ_PEND) ?
                   writedata[13:0] & wrMask[13:0] : 14'h0000) &
                   ~((accTake && !irq_lp_pkg::SHARED_SLOTS[selIdx]) ?
                   14'(16'h0001 << selIdx) : 14'h0000)) | irqEvt;
      nmiFlag_r <= (nmiFlag_r & ~((sfrWr && address == irq_lp_pkg::OFS_NMI &&
                   byteenable[0]) ? writedata[2:0] : 3'h0)) | nmiEvt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rstFlag_r <= 3'h1;
    end else if (ce) begin
      rstFlag_r <= (rstFlag_r & ~((sfrWr && address == irq_lp_pkg::OFS_RST_FLG) ?
                   writedata[2:0] : 3'h0)) | rstEvt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r  <= irq_lp_pkg::ST_START;
      cnt_r    <= 3'h0;
      accIdx_r <= 4'h0;
    end else if (ce) begin
      if (anyRst) begin
        state_r <= irq_lp_pkg::ST_START;
      end else begin
        case (state_r)
          irq_lp_pkg::ST_START: state_r <= irq_lp_pkg::ST_IDLE;
          irq_lp_pkg::ST_IDLE: begin
            cnt_r <= 3'h0;
            if (retTake) begin
              state_r <= irq_lp_pkg::ST_RET;
            end else if (accTake) begin
              state_r  <= irq_lp_pkg::ST_ACC;
              accIdx_r <= selIdx;
            end
          end
          irq_lp_pkg::ST_ACC: begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == irq_lp_pkg::ACC_LAST) begin
              state_r <= irq_lp_pkg::ST_IDLE;
            end
          end
          irq_lp_pkg::ST_RET: begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == irq_lp_pkg::RET_LAST) begin
              state_r <= irq_lp_pkg::ST_IDLE;
            end
          end
          default: state_r <= irq_lp_pkg::ST_START;
        endcase
      end
    end
  end

  // software status writes only land between sequences
  always_comb begin
    srNxt = sr_r;
    case (state_r)
      irq_lp_pkg::ST_START: srNxt = irq_lp_pkg::SR_RST;
      irq_lp_pkg::ST_IDLE: begin
        if (busWr && address == irq_lp_pkg::OFS_STATUS) begin
          srNxt = (sr_r & ~wrMask) | (writedata[15:0] & wrMask);
        end
      end
      irq_lp_pkg::ST_ACC: begin
        if (cnt_r == 3'h1) begin
          srNxt = sr_r & irq_lp_pkg::SR_KEEP_ON_ACC;
        end
      end
      irq_lp_pkg::ST_RET: begin
        if (cnt_r == 3'h1) begin
          srNxt = memRdata;
        end
      end
      default: srNxt = sr_r;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sr_r    <= irq_lp_pkg::SR_RST;
      clkEn_r <= irq_lp_pkg::CLK_EN_RST;
    end else if (ce) begin
      sr_r    <= srNxt;
      // enables follow the next status so the mode moves on the same edge
      clkEn_r <= lpDecode(srNxt, dcoSrc_r);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp_r <= irq_lp_pkg::SP_RST;
    end else if (ce) begin
      if (retTake || (state_r == irq_lp_pkg::ST_RET && cnt_r == 3'h0)) begin
        sp_r <= sp_r + irq_lp_pkg::STACK_STEP;
      end else if (accTake || (state_r == irq_lp_pkg::ST_ACC && cnt_r == 3'h0)) begin
        sp_r <= sp_r - irq_lp_pkg::STACK_STEP;
      end else if (busWr && address == irq_lp_pkg::OFS_SP && state_r == irq_lp_pkg::ST_IDLE) begin
        sp_r <= (sp_r & ~wrMask) | (writedata[15:0] & wrMask);
      end
    end
  end

  // stack traffic: memory returns read data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      memReq_r <= '0;
    end else if (ce) begin
      memReq_r.rd <= 1'b0;
      memReq_r.wr <= 1'b0;
      if (retTake || (state_r == irq_lp_pkg::ST_RET && cnt_r == 3'h0)) begin
        memReq_r.rd   <= 1'b1;
        memReq_r.addr <= sp_r;
      end else if (accTake) begin
        memReq_r.wr    <= 1'b1;
        memReq_r.addr  <= sp_r - irq_lp_pkg::STACK_STEP;
        memReq_r.wdata <= nextPc;
      end else if (state_r == irq_lp_pkg::ST_ACC && cnt_r == 3'h0) begin
        memReq_r.wr    <= 1'b1;
        memReq_r.addr  <= sp_r - irq_lp_pkg::STACK_STEP;
        memReq_r.wdata <= sr_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pc_r      <= 16'h0000;
      pcLoad_r  <= 1'b0;
      vecAddr_r <= 16'h0000;
    end else if (ce) begin
      pcLoad_r <= 1'b0;
      if (state_r == irq_lp_pkg::ST_START && !anyRst) begin
        pc_r      <= vecTab[irq_lp_pkg::SLOT_RESET];
        vecAddr_r <= irq_lp_pkg::VEC_ADDR_BASE + {11'h000, irq_lp_pkg::SLOT_RESET, 1'b0};
        pcLoad_r  <= 1'b1;
      end else if (state_r == irq_lp_pkg::ST_ACC && cnt_r == irq_lp_pkg::ACC_LAST && !anyRst) begin
        pc_r      <= vecTab[accIdx_r];
        vecAddr_r <= irq_lp_pkg::VEC_ADDR_BASE + {11'h000, accIdx_r, 1'b0};
        pcLoad_r  <= 1'b1;
      end else if (state_r == irq_lp_pkg::ST_RET && cnt_r == 3'h2) begin
        pc_r <= memRdata;
      end else if (state_r == irq_lp_pkg::ST_RET && cnt_r == irq_lp_pkg::RET_LAST && !anyRst) begin
        pcLoad_r <= 1'b1;
      end
    end
  end

  assign waitrequest = waitreq_r;
  assign memReq      = memReq_r;
  assign pcOut       = pc_r;
  assign pcLoad      = pcLoad_r;
  assign vecAddr     = vecAddr_r;
  assign clkEn       = clkEn_r;

  sequence s_run;
    ce && !anyRst;
  endsequence

  sequence s_ret_start;
    retTake && ce;
  endsequence

  sequence s_acc_start;
    accTake && ce;
  endsequence

  property p_isr_return_instr_len;
    @(posedge clk_sys) disable iff (srst) s_ret_start ##1 s_run[*5] |=> pcLoad_r;
  endproperty
  a_isr_return_instr_len: assert property (p_isr_return_instr_len) else $error("return did not end in 5 cycles");

  property p_isr_return_instr_sr;
    @(posedge clk_sys) disable iff (srst)
      (state_r == irq_lp_pkg::ST_RET && cnt_r == 3'h1 && ce && !anyRst) |=>
      sr_r == $past(memRdata) && clkEn_r == lpDecode($past(memRdata), dcoSrc_r);
  endproperty
  a_isr_return_instr_sr: assert property (p_isr_return_instr_sr) else $error("popped status not applied");

  property p_acc_len;
    @(posedge clk_sys) disable iff (srst) s_acc_start ##1 s_run[*6] |=> pcLoad_r && pc_r == vecTab[accIdx_r];
  endproperty
  a_acc_len: assert property (p_acc_len) else $error("acceptance did not end in 6 cycles");

  property p_prio;
    @(posedge clk_sys) disable iff (srst)
      accTake |-> (reqVec & ~((16'h0002 << selIdx) - 16'h0001)) == 16'h0000 && reqVec[selIdx];
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority chosen");

  property p_vec_addr;
    @(posedge clk_sys) disable iff (srst)
      pcLoad_r |-> vecAddr_r >= irq_lp_pkg::VEC_ADDR_BASE && !vecAddr_r[0];
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector outside table");

  property p_acc_sr;
    @(posedge clk_sys) disable iff (srst)
      (state_r == irq_lp_pkg::ST_ACC && cnt_r == 3'h1 && ce && !anyRst) |=>
      sr_r == ($past(sr_r) & irq_lp_pkg::SR_KEEP_ON_ACC) && clkEn_r.coreRun;
  endproperty
  a_acc_sr: assert property (p_acc_sr) else $error("status not cleared on acceptance");

  property p_wake;
    @(posedge clk_sys) disable iff (srst)
      (state_r == irq_lp_pkg::ST_IDLE && sr_r[irq_lp_pkg::SR_HALT] && reqValid && !retiReq && ce && !anyRst)
      |=> state_r == irq_lp_pkg::ST_ACC;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on enabled request");

  property p_lp0;
    @(posedge clk_sys) disable iff (srst)
      sr_r[irq_lp_pkg::SR_HALT] |-> !clkEn_r.mainClk && !clkEn_r.coreRun;
  endproperty
  a_lp0: assert property (p_lp0) else $error("core or main clock runs while halted");

  property p_lp4;
    @(posedge clk_sys) disable iff (srst)
      (sr_r[irq_lp_pkg::SR_HALT] && sr_r[irq_lp_pkg::SR_XOSC]) |->
      clkEn_r == irq_lp_pkg::clk_en_t'(7'h00);
  endproperty
  a_lp4: assert property (p_lp4) else $error("clock left on in deepest sleep");

  property p_pop;
    @(posedge clk_sys) disable iff (srst)
      s_ret_start |=> memReq_r.rd && memReq_r.addr == $past(sp_r) &&
      sp_r == $past(sp_r) + irq_lp_pkg::STACK_STEP;
  endproperty
  a_pop: assert property (p_pop) else $error("pop address or step wrong");

endmodule : irq_vector_and_lowpower_ctrl

// [src/irq_lp_pkg.sv]
package irq_lp_pkg;

  // register byte offsets on the slave port
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_SP       = 8'h04;
  localparam logic [7:0] OFS_PC       = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_PEND = 8'h10;
  localparam logic [7:0] OFS_NMI      = 8'h14;
  localparam logic [7:0] OFS_RST_FLG  = 8'h18;
  localparam logic [7:0] OFS_CLK_CFG  = 8'h1C;
  localparam logic [1:0] VEC_PAGE     = 2'h1;

  // status_word bit positions
  localparam int SR_GIE  = 3;
  localparam int SR_HALT = 4;
  localparam int SR_XOSC = 5;
  localparam int SR_LOOP_CTRL_STOP = 6;
  localparam int SR_DC_GEN_STOP = 7;
  localparam logic [15:0] SR_KEEP_ON_ACC = 16'h0040;
  localparam logic [15:0] SR_RST         = 16'h0000;
  localparam logic [15:0] SP_RST         = 16'h0000;
  localparam logic [15:0] STACK_STEP     = 16'h0002;

  // vector table: slot i sits at word address VEC_ADDR_BASE + 2*i
  localparam logic [15:0] VEC_ADDR_BASE = 16'hFFE0;
  localparam logic [3:0]  SLOT_RESET    = 4'hF;
  localparam logic [3:0]  SLOT_NMI      = 4'hE;
  localparam logic [3:0]  SLOT_WDT      = 4'hA;
  localparam int          NUM_SLOTS     = 16;
  localparam int          NUM_MASKABLE  = 14;
  localparam logic [15:0] SHARED_SLOTS  = 16'hC000;

  // sequence lengths in cycles, counter runs 0..N-1
  localparam logic [2:0] ACC_LAST = 3'h5;
  localparam logic [2:0] RET_LAST = 3'h4;

  // reset flag bits
  localparam int RF_EXT = 0;
  localparam int RF_WDT = 1;
  localparam int RF_KEY = 2;

  typedef struct packed {
    logic coreRun;
    logic mainClk;
    logic subClk;
    logic auxClk;
    logic digital_osc;
    logic dcGen;
    logic xtal;
  } clk_en_t;

  localparam clk_en_t CLK_EN_RST = 7'h7F;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef enum logic [1:0] {ST_START, ST_IDLE, ST_ACC, ST_RET} seq_state_t;

endpackage : irq_lp_pkg

// [src/irq_prio_enc.sv]
module irq_prio_enc (
  input  wire logic [15:0] req,
  output logic             valid,
  output logic [3:0]       idx
);
  // fixed priority: the higher slot number always wins
  always_comb begin
    valid = 1'b0;
    idx   = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = 4'(i);
      end
    end
  end
endmodule : irq_prio_enc

// [tb/core_model.sv]
module core_model (
  input  wire irq_lp_pkg::mem_req_t memReq,
  input  wire logic                 clk_sys,
  output logic [15:0]               memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // word window on the stack, wide enough for the nesting depth used here
  logic [15:0] mem [0:255];
  initial memRdata = 16'h0000;
  always @(posedge clk_sys) begin
    if (memReq.wr) begin
      mem[memReq.addr[8:1]] <= memReq.wdata;
    end
    if (memReq.rd) begin
      memRdata <= mem[memReq.addr[8:1]];
    end else begin
      // released bus toggles so a sample one cycle late can never pass for data
      memRdata <= ~memRdata;
    end
  end
endmodule : core_model

// [tb/irq_vector_and_lowpower_ctrl_test.sv]
module irq_vector_and_lowpower_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys    = 1'b0;
  logic                 srst       = 1'b1;
  logic                 ce         = 1'b1;
  logic [7:0]           address    = 8'h00;
  logic                 read       = 1'b0;
  logic                 write      = 1'b0;
  logic [31:0]          writedata  = 32'h0;
  logic [3:0]           byteenable = 4'h0;
  logic                 instrDone  = 1'b0;
  logic                 retiReq    = 1'b0;
  logic [15:0]          nextPc     = 16'h0;
  logic [13:0]          irqEvt     = 14'h0;
  logic [2:0]           nmiEvt     = 3'h0;
  logic [2:0]           rstEvt     = 3'h0;
  logic [31:0]          readdata;
  logic                 waitrequest;
  logic [15:0]          memRdata;
  irq_lp_pkg::mem_req_t memReq;
  logic [15:0]          pcOut;
  logic                 pcLoad;
  logic [15:0]          vecAddr;
  irq_lp_pkg::clk_en_t  clkEn;
  logic [31:0]          rd;
  int                   fails = 0;
  int                   check_count = 0;

  irq_vector_and_lowpower_ctrl i_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .instrDone(instrDone), .retiReq(retiReq), .nextPc(nextPc),
    .memRdata(memRdata), .irqEvt(irqEvt), .nmiEvt(nmiEvt), .rstEvt(rstEvt), .memReq(memReq),
    .pcOut(pcOut), .pcLoad(pcLoad), .vecAddr(vecAddr), .clkEn(clkEn));
  core_model i_core (.memReq(memReq), .clk_sys(clk_sys), .memRdata(memRdata));

  always #4 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick

  // one Avalon transfer; an idle cycle follows so calls may run back to back
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    // no cycle count assumed here: only the watchdog ends a hung wait
    do begin
      tick(1);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    tick(1);
  endtask : bus

  task automatic await_load(output int m);
    m = 0;
    while (pcLoad !== 1'b1 && m < 20) begin
      tick(1);
      m++;
    end
    if (m >= 20) begin
      fails++;
    end
  endtask : await_load

  task automatic take(input logic [15:0] vec, input logic [15:0] pc);
    int m;
    m = 0;
    while (memReq.wr !== 1'b1 && m < 20) begin
      tick(1);
      m++;
    end
    await_load(m);
    check("accept cycles", m, 6);
    check("vector address", vecAddr, vec);
    check("handler address", pcOut, pc);
  endtask : take

  task automatic t_reset();
    int m;
    tick(20);
    srst <= 1'b0;
    await_load(m);
    check("boot vector", vecAddr, 16'hFFFE);
    check("boot clocks", clkEn, 7'h7F);
    tick(1);
    for (int i = 0; i < 16; i++) begin
      bus(8'h40 + 8'(4 * i), 1'b1, 32'hC000 + 32'(i) * 32'h100, 4'h3);
    end
  endtask : t_reset

  task automatic t_modes();
    logic [7:0] sr [6] = '{8'h00, 8'h10, 8'h50, 8'h90, 8'hD0, 8'hF0};
    logic [6:0] en [6] = '{7'h7F, 7'h1F, 7'h19, 7'h0B, 7'h09, 7'h00};
    bus(irq_lp_pkg::OFS_CLK_CFG, 1'b1, 32'h0, 4'h1);
    for (int i = 0; i < 6; i++) begin
      bus(irq_lp_pkg::OFS_STATUS, 1'b1, {24'h0, sr[i]}, 4'h1);
      tick(1);
      check("mode clocks", clkEn, en[i]);
    end
    bus(irq_lp_pkg::OFS_CLK_CFG, 1'b1, 32'h1, 4'h1);
    bus(irq_lp_pkg::OFS_STATUS, 1'b1, 32'h50, 4'h1);
    tick(1);
    check("level1 dc gen kept", clkEn, 7'h1B);
  endtask : t_modes

  task automatic t_wake();
    bus(irq_lp_pkg::OFS_SP, 1'b1, 32'h0100, 4'h3);
    bus(irq_lp_pkg::OFS_IRQ_EN, 1'b1, 32'h0408, 4'hF);
    bus(irq_lp_pkg::OFS_IRQ_EN, 1'b0, 32'h0, 4'hF);
    check("wide sfr write", rd, 32'h0);
    bus(8'h30, 1'b0, 32'h0, 4'hF);
    check("unmapped read", rd, 32'h0);
    bus(irq_lp_pkg::OFS_IRQ_EN, 1'b1, 32'h08, 4'h1);
    bus(irq_lp_pkg::OFS_IRQ_EN, 1'b1, 32'h0400, 4'h2);
    bus(irq_lp_pkg::OFS_STATUS, 1'b1, 32'hD8, 4'h1);
    nextPc <= 16'h1234;
    irqEvt <= 14'h0408;
    tick(1);
    irqEvt <= 14'h0;
    take(16'hFFF4, 16'hCA00);
    check("stacked pc", i_core.mem[8'h7F], 16'h1234);
    check("stacked status", i_core.mem[8'h7E], 16'h00D8);
    check("woken clocks", clkEn, 7'h7F);
    bus(irq_lp_pkg::OFS_STATUS, 1'b0, 32'h0, 4'h3);
    check("status after accept", rd, 32'h40);
    bus(irq_lp_pkg::OFS_IRQ_PEND, 1'b0, 32'h0, 4'h3);
    check("pending after accept", rd, 32'h08);
  endtask : t_wake

  task automatic t_nest();
    nextPc <= 16'h2222;
    bus(irq_lp_pkg::OFS_STATUS, 1'b1, 32'h48, 4'h1);
    instrDone <= 1'b1;
    tick(1);
    instrDone <= 1'b0;
    take(16'hFFE6, 16'hC300);
    check("nested status", i_core.mem[8'h7C], 16'h0048);
  endtask : t_nest

  task automatic t_return();
    int m;
    m = 0;
    // the routine rewrites its stacked copy to fall into level 2 on return
    i_core.mem[8'h7C] = 16'h0098;
    retiReq <= 1'b1;
    tick(1);
    retiReq <= 1'b0;
    while (memReq.rd !== 1'b1 && m < 20) begin
      tick(1);
      m++;
    end
    check("first pop", memReq.addr, 16'h00F8);
    tick(1);
    check("second pop", {memReq.rd, memReq.addr}, {1'b1, 16'h00FA});
    await_load(m);
    check("return cycles", m + 1, 5);
    check("resume address", pcOut, 16'h2222);
    tick(2);
    check("popped mode clocks", clkEn, 7'h0B);
    bus(irq_lp_pkg::OFS_STATUS, 1'b0, 32'h0, 4'h3);
    check("popped status", rd, 32'h98);
    bus(irq_lp_pkg::OFS_SP, 1'b0, 32'h0, 4'h3);
    check("stack pointer", rd, 32'hFC);
  endtask : t_return

  task automatic t_nmi_rst();
    int m;
    bus(irq_lp_pkg::OFS_NMI, 1'b1, 32'h0200, 4'h2);
    nmiEvt <= 3'h2;
    tick(1);
    nmiEvt <= 3'h0;
    take(16'hFFFC, 16'hCE00);
    bus(irq_lp_pkg::OFS_NMI, 1'b0, 32'h0, 4'h3);
    check("nmi flags", rd, 32'h0002);
    for (int i = 0; i < 3; i++) begin
      rstEvt <= 3'(1 << i);
      tick(1);
      rstEvt <= 3'h0;
      await_load(m);
      check("reset vector", vecAddr, 16'hFFFE);
      check("reset handler", pcOut, 16'hCF00);
    end
    bus(irq_lp_pkg::OFS_RST_FLG, 1'b0, 32'h0, 4'h1);
    check("reset causes", rd, 32'h7);
  endtask : t_nmi_rst

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // the whole sequence needs well under a thousand cycles
  initial begin
    tick(20000);
    fails++;
    print_verdict();
  end

  initial begin
    t_reset();
    t_modes();
    t_wake();
    t_nest();
    t_return();
    t_nmi_rst();
    print_verdict();
  end
endmodule : irq_vector_and_lowpower_ctrl_test
